// ---- timer16_pkg.sv ----
// Constants, field layout and state type of the 16-bit timer compare-output block.
package timer16_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] FORCE_OFS = 8'h04;
  localparam logic [7:0] COUNT_OFS = 8'h08;
  localparam logic [7:0] CMP_A_OFS = 8'h0C;
  localparam logic [7:0] CMP_B_OFS = 8'h10;
  localparam logic [7:0] CAPTURE_OFS = 8'h14;
  localparam logic [7:0] FLAGS_OFS = 8'h18;
  localparam logic [7:0] OUT_STATE_OFS = 8'h1C;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_WGM_LSB = 0;
  localparam int CTRL_COM_A_LSB = 4;
  localparam int CTRL_COM_B_LSB = 6;
  localparam int CTRL_CS_LSB = 8;
  localparam int FORCE_A_BIT = 0;
  localparam int FORCE_B_BIT = 1;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_MATCH_A_BIT = 1;
  localparam int FLAG_MATCH_B_BIT = 2;
  localparam int FLAG_CAPTURE_BIT = 3;
  localparam int OUT_A_BIT = 0;
  localparam int OUT_B_BIT = 1;

  // ****************************************
  // Modes and encodings
  // ****************************************
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_CTC_CMP_A = 4'h4;
  localparam logic [3:0] WGM_CTC_CAPTURE = 4'hC;
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [9:0] PRESC_MASK_8 = 10'h007;
  localparam logic [9:0] PRESC_MASK_64 = 10'h03F;
  localparam logic [9:0] PRESC_MASK_256 = 10'h0FF;
  localparam logic [9:0] PRESC_MASK_1024 = 10'h3FF;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNTER_FLOOR = 16'h0000;

  // ****************************************
  // State and reset value
  // ****************************************
  typedef struct packed {
    logic [3:0] waveform_generation_mode;
    logic [1:0] compare_output_mode_a;
    logic [1:0] compare_output_mode_b;
    logic [2:0] clock_select;
    logic [9:0] prescale;
    logic [15:0] counter_value;
    logic [15:0] compare_value_a;
    logic [15:0] compare_value_b;
    logic [15:0] capture_value;
    logic match_block;
    logic overflow_flag;
    logic compare_match_flag_a;
    logic compare_match_flag_b;
    logic capture_flag;
    logic [1:0] compare_output_state;
    logic [31:0] prdata;
  } timer_state_t;

  localparam timer_state_t STATE_RST = '0;

endpackage

// ---- timer16_compare_out.sv ----
// 16-bit timer with Normal and clear-on-match counting and two compare-output channels.
//
// Behaviour
// - Reset clears compare output state to zero.
// - Nonzero mode replaces port value with state.
// - Pin drives only when direction bit selects output.
// - State can be preset before pin is enabled.
// - Mode field never touches input capture.
// - Mode zero leaves state unchanged on match.
// - New mode applies at next match after write.
// - Force strobe applies action immediately, non-PWM.
// - Counting depends only on waveform mode and clock select.
// - Mode selects set/clear/toggle or PWM polarity.
// - Waveform mode zero increments and wraps at max.
// - Normal mode sets overflow flag at zero.
// - Overflow flag clears when interrupt is serviced.
// - Normal mode accepts counter writes anytime.
// - Clear-on-match clears at compare A or capture.
// - Top register's flag rises at each top.
// - Top is not buffered; low top wraps first.
// - Channel A mode one toggles state each match.
// - Toggle rate uses prescale 1,8,64,256,1024.
// - Clear-on-match sets overflow on max to zero.
// - Force neither sets flag nor clears counter.
// - Counter write blocks matches next timer cycle.
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps

module timer16_compare_out
  import timer16_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port_out_a,
  input wire logic output_pin_a_direction_bit,
  input wire logic port_out_b,
  input wire logic output_pin_b_direction_bit,
  output logic pin_a_out,
  output logic pin_a_oe_n,
  output logic pin_b_out,
  output logic pin_b_oe_n,
  input wire logic capture_event,
  input wire logic overflow_serviced,
  input wire logic match_a_serviced,
  input wire logic match_b_serviced,
  input wire logic capture_serviced,
  output logic overflow_flag,
  output logic compare_match_flag_a,
  output logic compare_match_flag_b,
  output logic capture_flag
);

  // ****************************************
  // Helper functions
  // ****************************************
  // Next output state at a compare match.
  function automatic logic match_next(input logic [1:0] mode, input logic non_pwm, input logic cur);
    logic nxt;
    nxt = cur;
    if (non_pwm) begin
      case (mode)
        COM_TOGGLE: nxt = ~cur;
        COM_CLEAR: nxt = 1'b0;
        COM_SET: nxt = 1'b1;
        default: nxt = cur;
      endcase
    end else begin
      case (mode)
        COM_CLEAR: nxt = 1'b0;
        COM_SET: nxt = 1'b1;
        default: nxt = cur;
      endcase
    end
    return nxt;
  endfunction

  // Next output state when a PWM count passes the floor.
  function automatic logic floor_next(input logic [1:0] mode, input logic cur);
    logic nxt;
    nxt = cur;
    case (mode)
      COM_CLEAR: nxt = 1'b1;
      COM_SET: nxt = 1'b0;
      default: nxt = cur;
    endcase
    return nxt;
  endfunction

  // ****************************************
  // State
  // ****************************************
  timer_state_t q;
  timer_state_t d;
  logic tick;
  logic non_pwm;
  logic clear_on_match_mode;
  logic live;
  logic [15:0] top;
  logic match_a;
  logic match_b;
  logic top_hit;
  logic wrap;
  logic setup;
  logic wr;
  logic mapped;
  logic [31:0] rd;

  // ****************************************
  // APB decode
  // ****************************************
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    mapped = 1'b1;
    case (paddr)
      CTRL_OFS: rd = 32'({q.clock_select, q.compare_output_mode_b, q.compare_output_mode_a,
                           q.waveform_generation_mode});
      FORCE_OFS: rd = 32'h0000_0000;
      COUNT_OFS: rd = 32'(q.counter_value);
      CMP_A_OFS: rd = 32'(q.compare_value_a);
      CMP_B_OFS: rd = 32'(q.compare_value_b);
      CAPTURE_OFS: rd = 32'(q.capture_value);
      FLAGS_OFS: rd = 32'({q.capture_flag, q.compare_match_flag_b, q.compare_match_flag_a, q.overflow_flag});
      OUT_STATE_OFS: rd = 32'(q.compare_output_state);
      default: begin
        rd = 32'h0000_0000;
        mapped = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Timer clock and compare decode
  // ****************************************
  always_comb begin
    case (q.clock_select)
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = (q.prescale & PRESC_MASK_8) == PRESC_MASK_8;
      CS_DIV64: tick = (q.prescale & PRESC_MASK_64) == PRESC_MASK_64;
      CS_DIV256: tick = (q.prescale & PRESC_MASK_256) == PRESC_MASK_256;
      CS_DIV1024: tick = (q.prescale & PRESC_MASK_1024) == PRESC_MASK_1024;
      default: tick = 1'b0;
    endcase
  end

  assign non_pwm = (q.waveform_generation_mode == WGM_NORMAL) || (q.waveform_generation_mode == WGM_CTC_CMP_A) ||
                   (q.waveform_generation_mode == WGM_CTC_CAPTURE);
  assign clear_on_match_mode = (q.waveform_generation_mode == WGM_CTC_CMP_A) || (q.waveform_generation_mode == WGM_CTC_CAPTURE);
  assign top = (q.waveform_generation_mode == WGM_CTC_CAPTURE) ? q.capture_value : q.compare_value_a;
  assign live = tick & ~q.match_block;
  assign match_a = live & (q.counter_value == q.compare_value_a);
  assign match_b = live & (q.counter_value == q.compare_value_b);
  assign top_hit = live & clear_on_match_mode & (q.counter_value == top);
  assign wrap = tick & (q.counter_value == COUNT_MAX);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    d.prescale = q.prescale + 10'h001;
    if (setup) begin
      d.prdata = rd;
    end
    // Register writes and flag clears come first so hardware sets win; force and counter writes come last.
    if (wr) begin
      case (paddr)
        CTRL_OFS: begin
          d.waveform_generation_mode = pwdata[CTRL_WGM_LSB +: 4];
          d.compare_output_mode_a = pwdata[CTRL_COM_A_LSB +: 2];
          d.compare_output_mode_b = pwdata[CTRL_COM_B_LSB +: 2];
          d.clock_select = pwdata[CTRL_CS_LSB +: 3];
        end
        CMP_A_OFS: d.compare_value_a = pwdata[15:0];
        CMP_B_OFS: d.compare_value_b = pwdata[15:0];
        CAPTURE_OFS: d.capture_value = pwdata[15:0];
        FLAGS_OFS: begin
          if (pwdata[FLAG_OVF_BIT]) begin
            d.overflow_flag = 1'b0;
          end
          if (pwdata[FLAG_MATCH_A_BIT]) begin
            d.compare_match_flag_a = 1'b0;
          end
          if (pwdata[FLAG_MATCH_B_BIT]) begin
            d.compare_match_flag_b = 1'b0;
          end
          if (pwdata[FLAG_CAPTURE_BIT]) begin
            d.capture_flag = 1'b0;
          end
        end
        OUT_STATE_OFS: d.compare_output_state = pwdata[1:0];
        default: d.prescale = d.prescale;
      endcase
    end
    if (overflow_serviced) begin
      d.overflow_flag = 1'b0;
    end
    if (match_a_serviced) begin
      d.compare_match_flag_a = 1'b0;
    end
    if (match_b_serviced) begin
      d.compare_match_flag_b = 1'b0;
    end
    if (capture_serviced) begin
      d.capture_flag = 1'b0;
    end
    // Counting follows only the waveform mode and the clock select.
    if (tick) begin
      d.match_block = 1'b0;
      d.counter_value = top_hit ? COUNTER_FLOOR : q.counter_value + 16'h0001;
    end
    if (wrap) begin
      d.overflow_flag = 1'b1;
    end
    if (match_a) begin
      d.compare_match_flag_a = 1'b1;
      d.compare_output_state[OUT_A_BIT] = match_next(q.compare_output_mode_a, non_pwm,
                                                     q.compare_output_state[OUT_A_BIT]);
    end
    if (match_b) begin
      d.compare_match_flag_b = 1'b1;
      d.compare_output_state[OUT_B_BIT] = match_next(q.compare_output_mode_b, non_pwm,
                                                     q.compare_output_state[OUT_B_BIT]);
    end
    if (!non_pwm && wrap) begin
      d.compare_output_state[OUT_A_BIT] = floor_next(q.compare_output_mode_a, q.compare_output_state[OUT_A_BIT]);
      d.compare_output_state[OUT_B_BIT] = floor_next(q.compare_output_mode_b, q.compare_output_state[OUT_B_BIT]);
    end
    if (top_hit && q.waveform_generation_mode == WGM_CTC_CAPTURE) begin
      d.capture_flag = 1'b1;
    end
    // The capture input is disabled while the capture register sets the top.
    if (capture_event && q.waveform_generation_mode != WGM_CTC_CAPTURE) begin
      d.capture_value = q.counter_value;
      d.capture_flag = 1'b1;
    end
    // Force acts on the output only; no flag, no counter clear.
    if (wr && paddr == FORCE_OFS && non_pwm) begin
      if (pwdata[FORCE_A_BIT]) begin
        d.compare_output_state[OUT_A_BIT] = match_next(q.compare_output_mode_a, 1'b1,
                                                       q.compare_output_state[OUT_A_BIT]);
      end
      if (pwdata[FORCE_B_BIT]) begin
        d.compare_output_state[OUT_B_BIT] = match_next(q.compare_output_mode_b, 1'b1,
                                                       q.compare_output_state[OUT_B_BIT]);
      end
    end
    // A counter write beats counting and blocks the next timer cycle's matches.
    if (wr && paddr == COUNT_OFS) begin
      d.counter_value = pwdata[15:0];
      d.match_block = 1'b1;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = q.prdata;
  assign pin_a_out = (q.compare_output_mode_a != COM_OFF) ? q.compare_output_state[OUT_A_BIT] : port_out_a;
  assign pin_b_out = (q.compare_output_mode_b != COM_OFF) ? q.compare_output_state[OUT_B_BIT] : port_out_b;
  assign pin_a_oe_n = ~output_pin_a_direction_bit;
  assign pin_b_oe_n = ~output_pin_b_direction_bit;
  assign overflow_flag = q.overflow_flag;
  assign compare_match_flag_a = q.compare_match_flag_a;
  assign compare_match_flag_b = q.compare_match_flag_b;
  assign capture_flag = q.capture_flag;

endmodule

// ---- timer16_compare_out_props.sv ----
// Port checker of the timer compare-output block.
`timescale 1ns/1ps
module timer16_compare_out_chk
  import timer16_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic port_out_a,
  input wire logic port_out_b,
  input wire logic output_pin_a_direction_bit,
  input wire logic output_pin_b_direction_bit,
  input wire logic pin_a_out,
  input wire logic pin_b_out,
  input wire logic pin_a_oe_n,
  input wire logic pin_b_oe_n,
  input wire logic overflow_serviced,
  input wire logic match_a_serviced,
  input wire logic match_b_serviced,
  input wire logic capture_serviced,
  input wire logic overflow_flag,
  input wire logic compare_match_flag_a,
  input wire logic compare_match_flag_b,
  input wire logic capture_flag
);
  logic flag_wr;
  assign flag_wr = psel && penable && pwrite && (paddr == FLAGS_OFS);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  oe_pin_a_a: assert property (pin_a_oe_n == !output_pin_a_direction_bit)
    else $error("pin a enable wrong");
  oe_pin_b_a: assert property (pin_b_oe_n == !output_pin_b_direction_bit)
    else $error("pin b enable wrong");
  reset_pins_a: assert property ($rose(presetn) |-> pin_a_out == port_out_a && pin_b_out == port_out_b)
    else $error("pins not from port after reset");
  ovf_clear_a: assert property ($fell(overflow_flag) |-> $past(overflow_serviced) || $past(flag_wr))
    else $error("overflow flag cleared without cause");
  match_a_clear_a: assert property ($fell(compare_match_flag_a) |-> $past(match_a_serviced) || $past(flag_wr))
    else $error("match a flag cleared without cause");
  match_b_clear_a: assert property ($fell(compare_match_flag_b) |-> $past(match_b_serviced) || $past(flag_wr))
    else $error("match b flag cleared without cause");
  cap_clear_a: assert property ($fell(capture_flag) |-> $past(capture_serviced) || $past(flag_wr))
    else $error("capture flag cleared without cause");
  access_ready_a: assert property (psel && !penable ##1 psel && penable |-> pready)
    else $error("access not answered");
endmodule
bind timer16_compare_out timer16_compare_out_chk u_chk (.*);

// ---- gpio_pin_model.sv ----
// General I/O port pin model facing the compare outputs.
`timescale 1ns/1ps
module gpio_pin_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] set_port,
  input wire logic [1:0] set_dir,
  input wire logic pin_a_out,
  input wire logic pin_a_oe_n,
  input wire logic pin_b_out,
  input wire logic pin_b_oe_n,
  output logic port_out_a,
  output logic port_out_b,
  output logic output_pin_a_direction_bit,
  output logic output_pin_b_direction_bit,
  output logic pad_a,
  output logic pad_b
);
  // Port value and direction bits load on the clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {port_out_b, port_out_a} <= 2'h0;
      {output_pin_b_direction_bit, output_pin_a_direction_bit} <= 2'h0;
    end else begin
      {port_out_b, port_out_a} <= set_port;
      {output_pin_b_direction_bit, output_pin_a_direction_bit} <= set_dir;
    end
  end
  // The pad has a pull-up and shows the driven level only while enabled.
  assign pad_a = pin_a_oe_n ? 1'b1 : pin_a_out;
  assign pad_b = pin_b_oe_n ? 1'b1 : pin_b_out;
endmodule

// ---- test_timer16_compare_out.sv ----
// Self-checking testbench of the timer compare-output block.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module test_timer16_compare_out
  import timer16_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, last_err, port_out_a, port_out_b, pad_a, pad_b;
  logic output_pin_a_direction_bit, output_pin_b_direction_bit, pin_a_out, pin_a_oe_n, pin_b_out, pin_b_oe_n;
  logic capture_event = 1'b0, overflow_serviced = 1'b0, match_a_serviced = 1'b0;
  logic match_b_serviced = 1'b0, capture_serviced = 1'b0;
  logic overflow_flag, compare_match_flag_a, compare_match_flag_b, capture_flag;
  logic [1:0] set_port = 2'h0, set_dir = 2'h0;
  int err_count = 0, total_checks = 0, cycles = 0;
  timer16_compare_out u_dut (.*);
  gpio_pin_model u_port (.*);
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 90000) begin
      err_count++;
      finish_test();
    end
  end
  // ****************************************
  // Bus cycles and helpers
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [31:0] ctrl(input logic [3:0] w, input logic [1:0] c, input logic [2:0] s);
    return {21'h0, s, 2'h0, c, w};
  endfunction
  task automatic pulse(input bit cap);
    @(posedge pclk);
    if (cap) begin
      capture_event <= 1'b1;
    end else begin
      overflow_serviced <= 1'b1;
    end
    @(posedge pclk);
    capture_event <= 1'b0;
    overflow_serviced <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic restart(input logic [7:0] a, input logic [15:0] top, input logic [15:0] cnt);
    apb(1'b1, CTRL_OFS, 32'h0000_0000);
    apb(1'b1, FLAGS_OFS, 32'h0000_000F);
    apb(1'b1, a, {16'h0000, top});
    apb(1'b1, COUNT_OFS, {16'h0000, cnt});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    apb(1'b0, OUT_STATE_OFS, 32'h0000_0000);
    `CHK("state", 32'h0000_0000, rdata)
    `CHK("pin a", port_out_a, pin_a_out)
    `CHK("pin b", port_out_b, pin_b_out)
    apb(1'b0, 8'h20, 32'h0000_0000);
    `CHK("unmapped", 1'b1, last_err)
    $display("reset test done");
  endtask
  task automatic t_force();
    logic [1:0] coms [5] = '{COM_TOGGLE, COM_CLEAR, COM_SET, COM_OFF, COM_TOGGLE};
    logic exp [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    set_port <= 2'h1;
    apb(1'b1, CTRL_OFS, ctrl(WGM_NORMAL, COM_CLEAR, CS_STOP));
    apb(1'b1, FORCE_OFS, 32'h0000_0001);
    `CHK("pin a", 1'b0, pin_a_out)
    `CHK("pad idle", 1'b1, pad_a)
    apb(1'b0, FLAGS_OFS, 32'h0000_0000);
    `CHK("force flags", 32'h0000_0000, rdata)
    set_dir <= 2'h3;
    apb(1'b0, COUNT_OFS, 32'h0000_0000);
    `CHK("force count", 32'h0000_0000, rdata)
    `CHK("pad driven", 1'b0, pad_a)
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, CTRL_OFS, ctrl(WGM_NORMAL, coms[i], CS_STOP));
      apb(1'b1, FORCE_OFS, 32'h0000_0001);
      apb(1'b0, OUT_STATE_OFS, 32'h0000_0000);
      `CHK("forced state", exp[i], rdata[0])
    end
    $display("force test done");
  endtask
  task automatic t_normal();
    restart(CMP_A_OFS, 16'h0000, 16'hFFFD);
    apb(1'b1, CTRL_OFS, ctrl(WGM_NORMAL, COM_OFF, CS_DIV1));
    for (int i = 0; i < 20 && overflow_flag !== 1'b1; i++) @(posedge pclk);
    `CHK("overflow", 1'b1, overflow_flag)
    apb(1'b0, COUNT_OFS, 32'h0000_0000);
    `CHK("wrapped", 1'b1, rdata[15:0] < 16'h0010)
    pulse(1'b0);
    `CHK("serviced", 1'b0, overflow_flag)
    apb(1'b1, COUNT_OFS, 32'h0000_0100);
    apb(1'b0, COUNT_OFS, 32'h0000_0000);
    `CHK("count write", 1'b1, rdata[15:0] >= 16'h0100 && rdata[15:0] < 16'h0108)
    $display("normal test done");
  endtask
  task automatic t_ctc();
    logic v;
    int n;
    logic [2:0] sel [2] = '{CS_DIV1, CS_DIV8};
    int per [2] = '{4, 32};
    restart(CMP_A_OFS, 16'h0003, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, CTRL_OFS, ctrl(WGM_CTC_CMP_A, COM_TOGGLE, sel[k]));
      v = pin_a_out;
      for (n = 0; n < 100 && pin_a_out === v; n++) @(posedge pclk);
      v = pin_a_out;
      for (n = 0; n < 100 && pin_a_out === v; n++) @(posedge pclk);
      `CHK("toggle period", per[k], n)
    end
    `CHK("match a", 1'b1, compare_match_flag_a)
    `CHK("match b", 1'b1, compare_match_flag_b)
    `CHK("no overflow", 1'b0, overflow_flag)
    $display("ctc test done");
  endtask
  task automatic t_capture_top();
    restart(CAPTURE_OFS, 16'h0005, 16'h0000);
    apb(1'b1, CTRL_OFS, ctrl(WGM_CTC_CAPTURE, COM_OFF, CS_DIV1));
    for (int i = 0; i < 20 && capture_flag !== 1'b1; i++) @(posedge pclk);
    `CHK("top flag", 1'b1, capture_flag)
    apb(1'b0, COUNT_OFS, 32'h0000_0000);
    `CHK("below top", 1'b1, rdata[15:0] <= 16'h0005)
    restart(CAPTURE_OFS, 16'h0005, 16'h000A);
    apb(1'b1, CTRL_OFS, ctrl(WGM_CTC_CAPTURE, COM_OFF, CS_DIV1));
    for (int i = 0; i < 70000 && overflow_flag !== 1'b1; i++) @(posedge pclk);
    `CHK("wrap overflow", 1'b1, overflow_flag)
    `CHK("missed top", 1'b0, capture_flag)
    $display("capture top test done");
  endtask
  task automatic t_block();
    restart(CMP_A_OFS, 16'h0007, 16'h0007);
    apb(1'b1, CTRL_OFS, ctrl(WGM_NORMAL, COM_TOGGLE, CS_DIV1));
    repeat (3) @(posedge pclk);
    `CHK("blocked match", 1'b0, compare_match_flag_a)
    pulse(1'b1);
    `CHK("capture", 1'b1, capture_flag)
    $display("block test done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_force();
    t_normal();
    t_ctc();
    t_capture_top();
    t_block();
    finish_test();
  end
endmodule
